// ---- hw/chg_regs_defs.vh ----
// constants for the charger mask and converter control register bank
// assumes an external serial engine that presents byte-wide register accesses
// Operation
// - charge-state mask blocks its interrupt pulse
// - input-presence mask blocks its interrupt
// - input fault mask blocks its interrupt
// - battery fault mask blocks its interrupt
// - system rail fault mask blocks its interrupt
// - boost path fault mask blocks its interrupt
// - thermal shutdown mask blocks its interrupt
// - temperature zone mask blocks its interrupt
// - converter enable runs scans, cleared by resets
// - results start at zero, never cleared
// - rate bit: continuous or one-shot pass
// - speed field sets 12 to 9 bits
// - averaging bit: single value or running average
// - seed bit: old value or fresh conversion
// - channel-off bits exclude their channels
// - register-reset command restores all writable fields
// - done mask applies in one-shot mode only
// - presence flag reads 1 after a change
`ifndef CHG_REGS_DEFS_VH
`define CHG_REGS_DEFS_VH
`define A_MISC_FLAG 8'h20
`define A_STAT_FLAG 8'h21
`define A_FAULT_FLAG 8'h22
`define A_MISC_MASK 8'h23
`define A_STAT_MASK 8'h24
`define A_FAULT_MASK 8'h25
`define A_CONV_CTRL 8'h26
`define A_CHAN_OFF 8'h27
`define A_RES_BASE 8'h28
`define A_RES_LAST 8'h37
`define WM_MISC 8'h40
`define WM_STAT 8'h09
`define WM_FAULT 8'hf9
`define WM_CTRL 8'hfc
`define WM_OFF 8'hff
`define RST_MISC 8'h00
`define RST_STAT 8'h00
`define RST_FAULT 8'h00
`define RST_CTRL 8'h30
`define RST_OFF 8'h00
`define B_EN 7
`define B_RATE 6
`define B_RES_HI 5
`define B_RES_LO 4
`define B_AVG 3
`define B_SEED 2
`define B_CHG 3
`define B_PRES 0
`define B_INF 7
`define B_BATF 6
`define B_SYSF 5
`define B_BSTF 4
`define B_TSH 3
`define B_TZ 0
`define B_DONE 6
`define CLK_NS 10
`define INT_PULSE_NS 1000
`define INT_PULSE_CYC ((`INT_PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define INT_CNT_W 8
`define SMP_W 12
`define RES_W 16
`define RES_ZERO 16'h0000
`endif

// ---- hw/conv_seq.v ----
// measurement scan sequencer with per-channel result store and averaging
// assumes the sample handshake acknowledge is already synchronised
`timescale 1ns/1ps
`include "chg_regs_defs.vh"
module conv_seq (
  input wire core_clk,
  input wire sys_rst,
  input wire conv_en,
  input wire avg_on,
  input wire seed_fresh,
  input wire [1:0] res_code,
  input wire [7:0] chan_off,
  input wire ack_s,
  input wire [`SMP_W-1:0] sample_data,
  input wire [2:0] rd_idx,
  output reg sample_req,
  output reg [2:0] sample_chan,
  output reg pass_done,
  output wire [`RES_W-1:0] rd_val
);
  localparam S_IDLE = 2'd0;
  localparam S_REQ = 2'd1;
  localparam S_REL = 2'd2;
  localparam S_NEXT = 2'd3;
  reg [1:0] state_r;
  reg [`RES_W-1:0] result_r [0:7];
  reg [7:0] seeded_r;
  wire [`SMP_W-1:0] trunc;
  wire [`RES_W-1:0] fresh;
  wire [`RES_W:0] sum;
  wire [`RES_W-1:0] avg;
  wire [`RES_W-1:0] old;
  reg [`RES_W-1:0] new_val;
  assign rd_val = result_r[rd_idx];
  // drop low bits to the selected effective resolution
  assign trunc = (sample_data >> res_code) << res_code;
  assign fresh = {{(`RES_W-`SMP_W){1'b0}}, trunc};
  assign old = result_r[sample_chan];
  assign sum = {1'b0, old} + {1'b0, fresh};
  assign avg = sum[`RES_W:1];
  always @* begin
    new_val = fresh;
    if (avg_on) begin
      if (seeded_r[sample_chan] || !seed_fresh) begin
        new_val = avg;
      end
    end
  end
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : slot
      // results start at zero and are never cleared afterwards
      always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          result_r[g] <= `RES_ZERO;
        end else if (state_r == S_REQ && ack_s && sample_chan == g) begin
          result_r[g] <= new_val;
        end
      end
    end
  endgenerate
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= S_IDLE;
      sample_req <= 1'b0;
      sample_chan <= 3'd7;
      pass_done <= 1'b0;
      seeded_r <= 8'h00;
    end else begin
      pass_done <= 1'b0;
      if (!avg_on || !conv_en) begin
        seeded_r <= 8'h00;
      end
      if (!conv_en) begin
        state_r <= S_IDLE;
        sample_req <= 1'b0;
        sample_chan <= 3'd7;
      end else begin
        case (state_r)
          S_IDLE: begin
            if (!ack_s) begin
              state_r <= S_NEXT;
            end
          end
          S_NEXT: begin
            if (chan_off[sample_chan]) begin
              // skip an excluded channel
              if (sample_chan == 3'd0) begin
                pass_done <= 1'b1;
                sample_chan <= 3'd7;
                state_r <= S_IDLE;
              end else begin
                sample_chan <= sample_chan - 3'd1;
              end
            end else begin
              sample_req <= 1'b1;
              state_r <= S_REQ;
            end
          end
          S_REQ: begin
            if (ack_s) begin
              sample_req <= 1'b0;
              if (avg_on) begin
                seeded_r[sample_chan] <= 1'b1;
              end
              state_r <= S_REL;
            end
          end
          default: begin
            if (!ack_s) begin
              if (sample_chan == 3'd0) begin
                pass_done <= 1'b1;
                sample_chan <= 3'd7;
                state_r <= S_IDLE;
              end else begin
                sample_chan <= sample_chan - 3'd1;
                state_r <= S_NEXT;
              end
            end
          end
        endcase
      end
    end
  end
endmodule

// ---- hw/irq_mask_and_adc_control.v ----
// charger register bank: event flags, interrupt masks, converter control
// assumes a serial engine on core_clk driving byte register strobes and
// analog event lines and a sample handshake that are asynchronous
`timescale 1ns/1ps
`include "chg_regs_defs.vh"
module irq_mask_and_adc_control (
  input wire core_clk,
  input wire sys_rst,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire reg_reset_cmd,
  input wire wd_expired,
  input wire charge_state_evt,
  input wire input_supply_evt,
  input wire input_fault_evt,
  input wire battery_fault_evt,
  input wire system_rail_fault_evt,
  input wire boost_path_fault_evt,
  input wire thermal_shutdown_evt,
  input wire temp_zone_evt,
  input wire sample_ack,
  input wire [`SMP_W-1:0] sample_data,
  output wire sample_req,
  output wire [2:0] sample_chan,
  output wire [1:0] sample_res,
  output wire irq_n_o,
  output wire irq_n_oe
);
  localparam NEV = 9;
  localparam E_CHG = 0;
  localparam E_PRES = 1;
  localparam E_INF = 2;
  localparam E_BATF = 3;
  localparam E_SYSF = 4;
  localparam E_BSTF = 5;
  localparam E_TSH = 6;
  localparam E_TZ = 7;
  localparam E_DONE = 8;
  localparam NSYNC = 9;
  localparam integer PULSE_CYC_I = `INT_PULSE_CYC;
  localparam [`INT_CNT_W-1:0] PULSE_CYC = PULSE_CYC_I[`INT_CNT_W-1:0];

  reg [7:0] misc_mask_r;
  reg [7:0] stat_mask_r;
  reg [7:0] fault_mask_r;
  reg [7:0] ctrl_r;
  reg [7:0] chan_off_r;
  reg [NEV-1:0] flag_r;
  reg [NEV-1:0] flag_nxt;
  reg [NSYNC-1:0] meta_r;
  reg [NSYNC-1:0] sync_r;
  reg [NSYNC-1:0] prev_r;
  reg [`INT_CNT_W-1:0] pulse_cnt_r;
  reg [`INT_CNT_W-1:0] pulse_cnt_nxt;
  reg [7:0] rdata_nxt;
  reg [NEV-1:0] rd_clr;
  reg [2:0] res_slot;
  wire [NSYNC-1:0] raw_in;
  wire [NEV-1:0] evt_set;
  wire [NEV-1:0] irq_off;
  wire [NEV-1:0] irq_fire;
  wire ack_s;
  wire pass_done;
  wire one_shot;
  wire [`RES_W-1:0] res_val;
  wire [7:0] res_off;
  wire in_res;

  assign raw_in = {sample_ack, temp_zone_evt, thermal_shutdown_evt,
                   boost_path_fault_evt, system_rail_fault_evt,
                   battery_fault_evt, input_fault_evt, input_supply_evt,
                   charge_state_evt};

  // three flops per asynchronous input; the second stage feeds logic and the third (prev_r) feeds edge detection
  genvar g;
  generate
    for (g = 0; g < NSYNC; g = g + 1) begin : sync
      always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
          prev_r[g] <= 1'b0;
        end else begin
          meta_r[g] <= raw_in[g];
          sync_r[g] <= meta_r[g];
          prev_r[g] <= sync_r[g];
        end
      end
    end
  endgenerate

  assign ack_s = sync_r[NSYNC-1];
  assign one_shot = ctrl_r[`B_RATE];
  assign sample_res = ctrl_r[`B_RES_HI:`B_RES_LO];

  // rising edges of the event lines, plus pass completion in one-shot mode
  assign evt_set[E_TZ:E_CHG] = sync_r[E_TZ:E_CHG] & ~prev_r[E_TZ:E_CHG];
  assign evt_set[E_DONE] = pass_done & one_shot;

  // mask bits aligned to the event vector
  assign irq_off[E_CHG] = stat_mask_r[`B_CHG];
  assign irq_off[E_PRES] = stat_mask_r[`B_PRES];
  assign irq_off[E_INF] = fault_mask_r[`B_INF];
  assign irq_off[E_BATF] = fault_mask_r[`B_BATF];
  assign irq_off[E_SYSF] = fault_mask_r[`B_SYSF];
  assign irq_off[E_BSTF] = fault_mask_r[`B_BSTF];
  assign irq_off[E_TSH] = fault_mask_r[`B_TSH];
  assign irq_off[E_TZ] = fault_mask_r[`B_TZ];
  assign irq_off[E_DONE] = misc_mask_r[`B_DONE];

  assign irq_fire = evt_set & ~irq_off;

  // result window: two bytes per slot, low byte at the even address
  assign res_off = reg_addr - `A_RES_BASE;
  assign in_res = (reg_addr >= `A_RES_BASE) && (reg_addr <= `A_RES_LAST);

  // slot order in the window versus channel-off bit index
  always @* begin
    case (res_off[3:1])
      3'd0: res_slot = 3'd7;
      3'd1: res_slot = 3'd6;
      3'd2: res_slot = 3'd5;
      3'd3: res_slot = 3'd0;
      3'd4: res_slot = 3'd4;
      3'd5: res_slot = 3'd3;
      3'd6: res_slot = 3'd2;
      default: res_slot = 3'd1;
    endcase
  end

  conv_seq u_seq (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .conv_en(ctrl_r[`B_EN]),
    .avg_on(ctrl_r[`B_AVG]),
    .seed_fresh(ctrl_r[`B_SEED]),
    .res_code(ctrl_r[`B_RES_HI:`B_RES_LO]),
    .chan_off(chan_off_r),
    .ack_s(ack_s),
    .sample_data(sample_data),
    .rd_idx(res_slot),
    .sample_req(sample_req),
    .sample_chan(sample_chan),
    .pass_done(pass_done),
    .rd_val(res_val)
  );

  // read mux and clear-on-read selection
  always @* begin
    rdata_nxt = 8'h00;
    rd_clr = {NEV{1'b0}};
    if (reg_addr == `A_MISC_FLAG) begin
      rdata_nxt[`B_DONE] = flag_r[E_DONE];
      rd_clr[E_DONE] = reg_rd;
    end else if (reg_addr == `A_STAT_FLAG) begin
      rdata_nxt[`B_CHG] = flag_r[E_CHG];
      rdata_nxt[`B_PRES] = flag_r[E_PRES];
      rd_clr[E_CHG] = reg_rd;
      rd_clr[E_PRES] = reg_rd;
    end else if (reg_addr == `A_FAULT_FLAG) begin
      rdata_nxt[`B_INF] = flag_r[E_INF];
      rdata_nxt[`B_BATF] = flag_r[E_BATF];
      rdata_nxt[`B_SYSF] = flag_r[E_SYSF];
      rdata_nxt[`B_BSTF] = flag_r[E_BSTF];
      rdata_nxt[`B_TSH] = flag_r[E_TSH];
      rdata_nxt[`B_TZ] = flag_r[E_TZ];
      rd_clr[E_TZ:E_INF] = {6{reg_rd}};
    end else if (reg_addr == `A_MISC_MASK) begin
      rdata_nxt = misc_mask_r & `WM_MISC;
    end else if (reg_addr == `A_STAT_MASK) begin
      rdata_nxt = stat_mask_r & `WM_STAT;
    end else if (reg_addr == `A_FAULT_MASK) begin
      rdata_nxt = fault_mask_r & `WM_FAULT;
    end else if (reg_addr == `A_CONV_CTRL) begin
      rdata_nxt = ctrl_r & `WM_CTRL;
    end else if (reg_addr == `A_CHAN_OFF) begin
      rdata_nxt = chan_off_r;
    end else if (in_res) begin
      rdata_nxt = res_off[0] ? res_val[15:8] : res_val[7:0];
    end
  end

  // a flag set in the same cycle as its clear-on-read survives
  always @* begin
    flag_nxt = (flag_r & ~rd_clr) | evt_set;
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
      flag_r <= {NEV{1'b0}};
    end else begin
      if (reg_rd) begin
        reg_rdata <= rdata_nxt;
      end
      flag_r <= flag_nxt;
    end
  end

  // writable fields; reserved bits are never stored
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      misc_mask_r <= `RST_MISC;
      stat_mask_r <= `RST_STAT;
      fault_mask_r <= `RST_FAULT;
      ctrl_r <= `RST_CTRL;
      chan_off_r <= `RST_OFF;
    end else if (reg_reset_cmd) begin
      misc_mask_r <= `RST_MISC;
      stat_mask_r <= `RST_STAT;
      fault_mask_r <= `RST_FAULT;
      ctrl_r <= `RST_CTRL;
      chan_off_r <= `RST_OFF;
    end else begin
      // a finished one-shot pass stops the converter
      if (pass_done && one_shot) begin
        ctrl_r[`B_EN] <= 1'b0;
      end
      if (reg_wr) begin
        if (reg_addr == `A_MISC_MASK) begin
          misc_mask_r <= reg_wdata & `WM_MISC;
        end else if (reg_addr == `A_STAT_MASK) begin
          stat_mask_r <= reg_wdata & `WM_STAT;
        end else if (reg_addr == `A_FAULT_MASK) begin
          fault_mask_r <= reg_wdata & `WM_FAULT;
        end else if (reg_addr == `A_CONV_CTRL) begin
          ctrl_r <= reg_wdata & `WM_CTRL;
        end else if (reg_addr == `A_CHAN_OFF) begin
          chan_off_r <= reg_wdata;
        end
      end
      if (wd_expired) begin
        ctrl_r[`B_EN] <= 1'b0;
      end
    end
  end

  // interrupt pulse: any unmasked event (re)starts a fixed-length low pulse
  always @* begin
    pulse_cnt_nxt = pulse_cnt_r;
    if (irq_fire[E_CHG]) begin
      pulse_cnt_nxt = PULSE_CYC;
    end
    if (irq_fire[E_PRES]) begin
      pulse_cnt_nxt = PULSE_CYC;
    end
    if (irq_fire[E_INF]) begin
      pulse_cnt_nxt = PULSE_CYC;
    end
    if (irq_fire[E_BATF]) begin
      pulse_cnt_nxt = PULSE_CYC;
    end
    if (irq_fire[E_SYSF]) begin
      pulse_cnt_nxt = PULSE_CYC;
    end
    if (irq_fire[E_BSTF]) begin
      pulse_cnt_nxt = PULSE_CYC;
    end
    if (irq_fire[E_TSH]) begin
      pulse_cnt_nxt = PULSE_CYC;
    end
    if (irq_fire[E_TZ]) begin
      pulse_cnt_nxt = PULSE_CYC;
    end
    if (irq_fire[E_DONE]) begin
      pulse_cnt_nxt = PULSE_CYC;
    end
    if (irq_fire == {NEV{1'b0}} && pulse_cnt_r != {`INT_CNT_W{1'b0}}) begin
      pulse_cnt_nxt = pulse_cnt_r - {{(`INT_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pulse_cnt_r <= {`INT_CNT_W{1'b0}};
    end else begin
      pulse_cnt_r <= pulse_cnt_nxt;
    end
  end

  // open-drain interrupt pin: only ever pulled low
  assign irq_n_o = 1'b0;
  assign irq_n_oe = (pulse_cnt_r != {`INT_CNT_W{1'b0}});

endmodule

// ---- sim/irq_mask_and_adc_control_chk.sv ----
// port assertions for the mask and converter control register bank
// assumes one core_clk domain and the async active-high sys_rst
`timescale 1ns/1ps
module irq_mask_and_adc_control_chk (
  input wire core_clk,
  input wire sys_rst,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire reg_reset_cmd,
  input wire wd_expired,
  input wire sample_req,
  input wire [2:0] sample_chan,
  input wire [1:0] sample_res,
  input wire irq_n_o,
  input wire irq_n_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  reg [7:0] hi_cnt_r;
  // cycles the interrupt pin has been pulled low, saturating
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hi_cnt_r <= 8'h00;
    end else if (!irq_n_oe) begin
      hi_cnt_r <= 8'h00;
    end else if (hi_cnt_r != 8'hff) begin
      hi_cnt_r <= hi_cnt_r + 8'h01;
    end
  end
  property p_rd_unmap; reg_rd && (reg_addr < 8'h20 || reg_addr > 8'h37) |=> reg_rdata == 8'h00; endproperty
  a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read not zero");
  property p_rd_stat; reg_rd && reg_addr == 8'h24 |=> (reg_rdata & 8'hf6) == 8'h00; endproperty
  a_rd_stat: assert property (p_rd_stat) else $error("status mask reserved bits set");
  property p_rd_fault; reg_rd && reg_addr == 8'h25 |=> (reg_rdata & 8'h06) == 8'h00; endproperty
  a_rd_fault: assert property (p_rd_fault) else $error("fault mask reserved bits set");
  property p_rd_ctrl; reg_rd && reg_addr == 8'h26 |=> reg_rdata[1:0] == 2'h0; endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("control reserved bits set");
  property p_res; reg_wr && reg_addr == 8'h26 && !reg_reset_cmd |=>
    {6'h00, sample_res} == (($past(reg_wdata) & 8'h30) >> 4); endproperty
  a_res: assert property (p_res) else $error("resolution code not taken");
  property p_rst_res; reg_reset_cmd |=> sample_res == 2'h3; endproperty
  a_rst_res: assert property (p_rst_res) else $error("resolution not restored");
  property p_wd_stop; wd_expired |-> ##[1:3] !sample_req; endproperty
  a_wd_stop: assert property (p_wd_stop) else $error("watchdog did not stop scan");
  property p_rst_stop; reg_reset_cmd |-> ##[1:3] !sample_req; endproperty
  a_rst_stop: assert property (p_rst_stop) else $error("reset command did not stop scan");
  property p_chan_hold; sample_req && $past(sample_req) |-> $stable(sample_chan); endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("channel changed during request");
  property p_pulse; $fell(irq_n_oe) |-> hi_cnt_r >= 8'h64; endproperty
  a_pulse: assert property (p_pulse) else $error("interrupt pulse too short");
  property p_od; irq_n_o == 1'b0; endproperty
  a_od: assert property (p_od) else $error("interrupt pin drives high");
endmodule
bind irq_mask_and_adc_control irq_mask_and_adc_control_chk u_irq_mask_and_adc_control_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_reset_cmd(reg_reset_cmd), .wd_expired(wd_expired),
  .sample_req(sample_req), .sample_chan(sample_chan), .sample_res(sample_res), .irq_n_o(irq_n_o),
  .irq_n_oe(irq_n_oe));

// ---- sim/conv_model.sv ----
// behavioural converter on the four-phase sample handshake
// assumes requests change just after core_clk rising edges
`timescale 1ns/1ps
module conv_model (
  input wire core_clk,
  input wire sample_req,
  input wire [2:0] sample_chan,
  input wire [11:0] base,
  output reg sample_ack,
  output reg [11:0] sample_data
);
  reg [2:0] wait_r;
  reg slow_r;
  initial begin
    sample_ack = 1'b0;
    sample_data = 12'h000;
    wait_r = 3'h0;
    slow_r = 1'b0;
  end
  // answers alternate prompt and slow; released data is inverted
  always @(posedge core_clk) begin
    if (!sample_ack && sample_req) begin
      if (wait_r == (slow_r ? 3'h6 : 3'h1)) begin
        sample_ack <= 1'b1;
        sample_data <= base ^ {sample_chan, 9'h000};
        wait_r <= 3'h0;
        slow_r <= !slow_r;
      end else begin
        wait_r <= wait_r + 3'h1;
      end
    end else if (sample_ack && !sample_req) begin
      sample_ack <= 1'b0;
      sample_data <= ~sample_data;
    end
  end
endmodule

// ---- sim/irq_mask_and_adc_control_tb_top.sv ----
// testbench for the mask and converter control register bank
// assumes the checker is bound to the bank and conv_model is compiled
`timescale 1ns/1ps
module irq_mask_and_adc_control_tb_top;
  reg core_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg [7:0] reg_addr = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_reset_cmd = 1'b0;
  reg wd_expired = 1'b0;
  reg [7:0] evt = 8'h00;
  reg [11:0] base = 12'h000;
  reg seen = 1'b0;
  wire [7:0] reg_rdata;
  wire sample_ack, sample_req, irq_n_o, irq_n_oe;
  wire [11:0] sample_data;
  wire [2:0] sample_chan;
  wire [1:0] sample_res;
  reg [15:0] e [0:7];
  reg [7:0] d, ma, fa, b;
  integer errors = 0;
  integer comparisons = 0;
  integer i, s;
  // mask bit per event, channel per result slot
  localparam [23:0] bpos = 24'h0e_5dc3;
  localparam [23:0] sch = 24'h29_c177;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (irq_n_oe === 1'b1) seen <= 1'b1;
  irq_mask_and_adc_control u_irq_mask_and_adc_control (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_reset_cmd(reg_reset_cmd), .wd_expired(wd_expired),
    .charge_state_evt(evt[0]), .input_supply_evt(evt[1]), .input_fault_evt(evt[2]),
    .battery_fault_evt(evt[3]), .system_rail_fault_evt(evt[4]), .boost_path_fault_evt(evt[5]),
    .thermal_shutdown_evt(evt[6]), .temp_zone_evt(evt[7]), .sample_ack(sample_ack),
    .sample_data(sample_data), .sample_req(sample_req), .sample_chan(sample_chan),
    .sample_res(sample_res), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe));
  conv_model u_conv_model (.core_clk(core_clk), .sample_req(sample_req), .sample_chan(sample_chan),
    .base(base), .sample_ack(sample_ack), .sample_data(sample_data));
  task end_of_test;
    begin
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(negedge core_clk);
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
    end
  endtask
  task get(input [7:0] a);
    begin
      @(negedge core_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge core_clk);
      reg_rd = 1'b0;
      @(negedge core_clk);
      d = reg_rdata;
    end
  endtask
  task rd(input [7:0] a, input [7:0] m, input [7:0] x);
    begin
      get(a);
      chk(d & m, x);
    end
  endtask
  task ev(input integer k);
    begin
      @(negedge core_clk);
      evt[k] = 1'b1;
      repeat (5) @(negedge core_clk);
      evt[k] = 1'b0;
    end
  endtask
  // one scan pass, then every result slot against the expected store
  task run(input [7:0] ctl, input [11:0] bs);
    integer n;
    reg [15:0] v;
    reg [2:0] c;
    reg [7:0] ra;
    begin
      base = bs;
      wr(8'h26, ctl);
      n = 0;
      d = 8'h80;
      while (d[7] && n < 200) begin
        get(8'h26);
        n = n + 1;
      end
      chk(d & 8'h80, 8'h00);
      ra = 8'h28;
      for (s = 0; s < 8; s = s + 1) begin
        c = sch[s*3+:3];
        if (c[2]) begin
          v = {4'h0, bs ^ {c, 9'h000}} & ~((16'h0001 << ctl[5:4]) - 16'h0001);
          e[s] = (ctl[3] && !ctl[2]) ? (e[s] + v) >> 1 : v;
        end
        rd(ra, 8'hff, e[s][7:0]);
        rd(ra + 8'h01, 8'hff, e[s][15:8]);
        ra = ra + 8'h02;
      end
    end
  endtask
  initial begin
    for (s = 0; s < 8; s = s + 1) e[s] = 16'h0000;
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    rd(8'h24, 8'hff, 8'h00);
    rd(8'h25, 8'hff, 8'h00);
    rd(8'h26, 8'hff, 8'h30);
    rd(8'h27, 8'hff, 8'h00);
    rd(8'h28, 8'hff, 8'h00);
    wr(8'h24, 8'hff);
    wr(8'h25, 8'hff);
    wr(8'h26, 8'h7c);
    wr(8'h27, 8'hff);
    wr(8'h50, 8'hff);
    rd(8'h24, 8'hff, 8'h09);
    rd(8'h25, 8'hff, 8'hf9);
    rd(8'h26, 8'hff, 8'h7c);
    rd(8'h27, 8'hff, 8'hff);
    rd(8'h50, 8'hff, 8'h00);
    wr(8'h26, 8'hfc);
    @(negedge core_clk);
    reg_reset_cmd = 1'b1;
    @(negedge core_clk);
    reg_reset_cmd = 1'b0;
    rd(8'h24, 8'hff, 8'h00);
    rd(8'h25, 8'hff, 8'h00);
    rd(8'h26, 8'hff, 8'h30);
    rd(8'h27, 8'hff, 8'h00);
    for (i = 0; i < 8; i = i + 1) begin
      ma = i < 2 ? 8'h24 : 8'h25;
      fa = i < 2 ? 8'h21 : 8'h22;
      b = 8'h01 << bpos[i*3+:3];
      wr(ma, 8'h00);
      seen = 1'b0;
      ev(i);
      repeat (110) @(negedge core_clk);
      chk({7'h00, seen}, 8'h01);
      rd(fa, b, b);
      wr(ma, b);
      seen = 1'b0;
      ev(i);
      repeat (20) @(negedge core_clk);
      chk({7'h00, seen}, 8'h00);
      rd(fa, b, b);
      rd(fa, b, 8'h00);
    end
    wr(8'h27, 8'h0f);
    seen = 1'b0;
    run(8'hc0, 12'h0a5);
    chk({7'h00, seen}, 8'h01);
    rd(8'h20, 8'h40, 8'h40);
    repeat (110) @(negedge core_clk);
    wr(8'h23, 8'h40);
    seen = 1'b0;
    run(8'hf0, 12'h0f3);
    chk({7'h00, seen}, 8'h00);
    run(8'hc8, 12'h055);
    run(8'hec, 12'h3c6);
    run(8'hd8, 12'h7e1);
    rd(8'h20, 8'h40, 8'h40);
    wr(8'h26, 8'h80);
    repeat (100) @(negedge core_clk);
    rd(8'h26, 8'hff, 8'h80);
    rd(8'h20, 8'h40, 8'h00);
    wd_expired = 1'b1;
    @(negedge core_clk);
    wd_expired = 1'b0;
    rd(8'h26, 8'hff, 8'h00);
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    errors = errors + 1;
    end_of_test;
  end
endmodule
